/* File: verilog/bss_sequencer.sv */
// What this block does
// - bias supply level is watched always and gates the whole start-up
// - bias above rising threshold starts the trip-level sample sequence
// - enable pin held low delays initialization until released and high
// - timing starts only once enable level exceeds its trip level
// - after enable crossing, wait a fixed settle delay before sampling
// - during settle, low-side driver off and trip-set current source on
// - sample time varies with setting, from one step to full scale time
// - sampled trip code held in counter/dac while bias stays up
// - soft-start begins when sampling completes
// - ramp reference from zero to final over fixed duration
// - ramp is a fixed number of equal digital steps
// - no external control of ramp rate or step count
// - after short init interval, error amplifier enabled during ramp
// - soft-start complete once ramp code reaches final level
// - low pre-bias: switches off until ramp passes sensed output
// - high pre-bias: switches off until soft-start ends
// - full soft-start runs without waiting for output voltage
// - enable low then released repeats full init with fresh sample
// - no new trip sample during overcurrent retries
// - overcurrent: output off, two dummy ramps then one real, repeating
`timescale 1ns/1ps
module bss_sequencer #(
	parameter int unsigned P_SETTLE_CYC  = bss_pkg::SETTLE_CYC,
	parameter int unsigned P_SAMPLE_CYC  = bss_pkg::SAMPLE_STEP_CYC,
	parameter int unsigned P_INIT_CYC    = bss_pkg::INIT_CYC,
	parameter int unsigned P_SS_STEP_CYC = bss_pkg::SS_STEP_CYC
) (
	input  wire logic                       i_clock,           // oscillator
	input  wire logic                       i_rst_n,           // por, low
	input  wire logic                       i_bias_ok,         // bias > thr
	input  wire logic                       i_enable_ok,       // en > trip
	input  wire logic                       i_trip_cmp,        // dac >= pin
	input  wire logic                       i_ramp_above_vout, // ref > vout
	input  wire logic                       i_overcurrent,     // ovc trip
	output logic                            o_lowside_off,     // ls drv off
	output logic                            o_trip_src_on,     // src on
	output logic [bss_pkg::TRIP_W-1:0]      o_trip_code,       // held dac
	output logic [bss_pkg::REF_W-1:0]       o_ref_code,        // ramp code
	output logic                            o_ea_enable,       // amp on
	output logic                            o_switch_enable,   // fets ok
	output logic                            o_ss_done,         // ramp done
	output logic                            o_hiccup           // retrying
);
	import bss_pkg::*;

	bss_tmr_if tmr_bus ();

	logic [SY_W-1:0] raw;
	logic [SY_W-1:0] sy;

	assign raw[SY_BIAS]  = i_bias_ok;
	assign raw[SY_EN]    = i_enable_ok;
	assign raw[SY_TRIP]  = i_trip_cmp;
	assign raw[SY_ABOVE] = i_ramp_above_vout;
	assign raw[SY_OVC]   = i_overcurrent;

	// comparator outputs are analogue and unrelated to the clock
	bss_sync #(
		.W (SY_W)
	) u_sync (
		.i_clock (i_clock),
		.i_rst_n (i_rst_n),
		.i_d     (raw),
		.o_q     (sy)
	);

	bss_timer u_timer (
		.i_clock (i_clock),
		.i_rst_n (i_rst_n),
		.tmr     (tmr_bus.tmr)
	);

	logic bias_ok;
	logic en_ok;
	logic trip_hit;
	logic ramp_above;
	logic ovc;

	assign bias_ok    = sy[SY_BIAS];
	assign en_ok      = sy[SY_EN];
	assign trip_hit   = sy[SY_TRIP];
	assign ramp_above = sy[SY_ABOVE];
	assign ovc        = sy[SY_OVC];

	// sequence state
	bss_state_t        st_q;
	bss_state_t        st_d;
	logic [TRIP_W-1:0] trip_q;
	logic [TRIP_W-1:0] trip_d;
	logic [REF_W-1:0]  ref_q;
	logic [REF_W-1:0]  ref_d;
	logic [1:0]        dummy_q;
	logic [1:0]        dummy_d;
	logic              pass_q;
	logic              pass_d;
	logic              tmr_start;
	logic [TW-1:0]     tmr_load;

	// registered outputs
	logic lowside_q;
	logic lowside_d;
	logic src_q;
	logic src_d;
	logic ea_q;
	logic ea_d;
	logic sw_q;
	logic sw_d;
	logic done_q;
	logic done_d;
	logic hic_q;
	logic hic_d;

	assign tmr_bus.start = tmr_start;
	assign tmr_bus.load  = tmr_load;

	always_comb begin
		st_d      = st_q;
		trip_d    = trip_q;
		ref_d     = ref_q;
		dummy_d   = dummy_q;
		pass_d    = pass_q;
		tmr_start = 1'b0;
		tmr_load  = '0;
		if (!bias_ok) begin
			// losing bias drops everything, held trip code included
			st_d    = ST_IDLE;
			trip_d  = TRIP_RST;
			ref_d   = REF_RST;
			dummy_d = 2'h0;
			pass_d  = 1'b0;
		end else if (!en_ok && st_q != ST_IDLE && st_q != ST_WAIT_EN) begin
			// disable after start: next release runs the full sequence
			st_d    = ST_WAIT_EN;
			ref_d   = REF_RST;
			dummy_d = 2'h0;
			pass_d  = 1'b0;
		end else begin
			case (st_q)
			ST_IDLE: begin
				st_d = ST_WAIT_EN;
			end
			ST_WAIT_EN: begin
				if (en_ok) begin
					st_d      = ST_SETTLE;
					tmr_start = 1'b1;
					tmr_load  = TW'(P_SETTLE_CYC);
				end
			end
			ST_SETTLE: begin
				if (tmr_bus.done) begin
					st_d      = ST_SAMPLE;
					trip_d    = TRIP_RST;
					tmr_start = 1'b1;
					tmr_load  = TW'(P_SAMPLE_CYC);
				end
			end
			ST_SAMPLE: begin
				// counts up until the dac reaches the pin voltage, so a
				// higher setting takes longer; zero setting ends after the first step
				if (tmr_bus.done) begin
					if (trip_hit || trip_q == TRIP_MAX) begin
						st_d      = ST_INIT;
						tmr_start = 1'b1;
						tmr_load  = TW'(P_INIT_CYC);
					end else begin
						trip_d    = trip_q + TRIP_W'(1);
						tmr_start = 1'b1;
						tmr_load  = TW'(P_SAMPLE_CYC);
					end
				end
			end
			ST_INIT: begin
				if (tmr_bus.done) begin
					st_d      = ST_RAMP;
					ref_d     = REF_RST;
					pass_d    = 1'b0;
					tmr_start = 1'b1;
					tmr_load  = TW'(P_SS_STEP_CYC);
				end
			end
			ST_RAMP: begin
				if (ovc && dummy_q == 2'h0) begin
					// real ramp tripped: restart as dummy time-outs
					dummy_d   = HICCUP_DUMMIES;
					ref_d     = REF_RST;
					pass_d    = 1'b0;
					tmr_start = 1'b1;
					tmr_load  = TW'(P_SS_STEP_CYC);
				end else begin
					if (dummy_q == 2'h0 && ramp_above) begin
						pass_d = 1'b1;
					end
					if (tmr_bus.done) begin
						if (ref_q == REF_LAST) begin
							ref_d = REF_FINAL;
							if (dummy_q == 2'h1) begin
								// last dummy over; trip code kept as is
								dummy_d   = 2'h0;
								st_d      = ST_INIT;
								tmr_start = 1'b1;
								tmr_load  = TW'(P_INIT_CYC);
							end else if (dummy_q != 2'h0) begin
								dummy_d   = dummy_q - 2'h1;
								ref_d     = REF_RST;
								tmr_start = 1'b1;
								tmr_load  = TW'(P_SS_STEP_CYC);
							end else begin
								st_d = ST_RUN;
							end
						end else begin
							ref_d     = ref_q + REF_W'(1);
							tmr_start = 1'b1;
							tmr_load  = TW'(P_SS_STEP_CYC);
						end
					end
				end
			end
			ST_RUN: begin
				if (ovc) begin
					st_d      = ST_RAMP;
					dummy_d   = HICCUP_DUMMIES;
					ref_d     = REF_RST;
					pass_d    = 1'b0;
					tmr_start = 1'b1;
					tmr_load  = TW'(P_SS_STEP_CYC);
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
			endcase
		end
	end

	// outputs follow the next state so every port leaves a flip-flop
	always_comb begin
		lowside_d = (st_d == ST_SETTLE) || (st_d == ST_SAMPLE);
		src_d     = (st_d == ST_SETTLE) || (st_d == ST_SAMPLE);
		ea_d      = (st_d == ST_RUN) ||
		            (st_d == ST_RAMP && dummy_d == 2'h0);
		// a high pre-bias never sees the ramp pass it, so it waits for run
		sw_d      = ea_d && (pass_d || st_d == ST_RUN);
		done_d    = (st_d == ST_RUN);
		hic_d     = (dummy_d != 2'h0);
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q      <= ST_IDLE;
			trip_q    <= TRIP_RST;
			ref_q     <= REF_RST;
			dummy_q   <= 2'h0;
			pass_q    <= 1'b0;
			lowside_q <= 1'b0;
			src_q     <= 1'b0;
			ea_q      <= 1'b0;
			sw_q      <= 1'b0;
			done_q    <= 1'b0;
			hic_q     <= 1'b0;
		end else begin
			st_q      <= st_d;
			trip_q    <= trip_d;
			ref_q     <= ref_d;
			dummy_q   <= dummy_d;
			pass_q    <= pass_d;
			lowside_q <= lowside_d;
			src_q     <= src_d;
			ea_q      <= ea_d;
			sw_q      <= sw_d;
			done_q    <= done_d;
			hic_q     <= hic_d;
		end
	end

	assign o_lowside_off   = lowside_q;
	assign o_trip_src_on   = src_q;
	assign o_trip_code     = trip_q;
	assign o_ref_code      = ref_q;
	assign o_ea_enable     = ea_q;
	assign o_switch_enable = sw_q;
	assign o_ss_done       = done_q;
	assign o_hiccup        = hic_q;
endmodule

/* File: verilog/bss_pkg.sv */
package bss_pkg;
	// clock and counter sizing
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned TW            = 20;
	localparam int unsigned TRIP_W        = 8;
	localparam int unsigned REF_W         = 7;

	// settle delay after the enable level is crossed (least time, round up)
	localparam real         SETTLE_MS     = 6.8;
	localparam int unsigned SETTLE_CYC    =
		int'($ceil(SETTLE_MS * 1.0e6 / CLK_PERIOD_NS));

	// soft-start ramp: fixed duration, fixed step count
	localparam real         SS_MS         = 6.8;
	localparam int unsigned SS_STEPS      = 64;
	localparam int unsigned SS_STEP_CYC   =
		int'($floor(SS_MS * 1.0e6 / CLK_PERIOD_NS / SS_STEPS));

	// trip sample: one dac code per step, full scale in the longest time
	localparam real         SAMPLE_MAX_MS = 3.4;
	localparam int unsigned TRIP_LEVELS   = 256;
	localparam int unsigned SAMPLE_STEP_CYC =
		int'($floor(SAMPLE_MAX_MS * 1.0e6 / CLK_PERIOD_NS / TRIP_LEVELS));

	// initialization interval between end of sampling and amplifier enable
	localparam real         INIT_US       = 100.0;
	localparam int unsigned INIT_CYC      =
		int'($ceil(INIT_US * 1.0e3 / CLK_PERIOD_NS));

	// hiccup retry: dummy soft-start time-outs before a real one
	localparam logic [1:0]  HICCUP_DUMMIES = 2'h2;

	// codes and reset values
	localparam logic [TRIP_W-1:0] TRIP_MAX   = 8'hff;
	localparam logic [TRIP_W-1:0] TRIP_RST   = 8'h00;
	localparam logic [REF_W-1:0]  REF_LAST   = 7'h3f;
	localparam logic [REF_W-1:0]  REF_FINAL  = 7'h40;
	localparam logic [REF_W-1:0]  REF_RST    = 7'h00;

	// synchronised comparator inputs, bit positions
	localparam int unsigned SY_BIAS  = 0;
	localparam int unsigned SY_EN    = 1;
	localparam int unsigned SY_TRIP  = 2;
	localparam int unsigned SY_ABOVE = 3;
	localparam int unsigned SY_OVC   = 4;
	localparam int unsigned SY_W     = 5;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT_EN,
		ST_SETTLE,
		ST_SAMPLE,
		ST_INIT,
		ST_RAMP,
		ST_RUN
	} bss_state_t;
endpackage

/* File: verilog/bss_tmr_if.sv */
`timescale 1ns/1ps
interface bss_tmr_if;
	import bss_pkg::*;
	logic          start;
	logic [TW-1:0] load;
	logic          done;
	modport ctl (output start, output load, input done);
	modport tmr (input start, input load, output done);
endinterface

/* File: verilog/bss_sync.sv */
`timescale 1ns/1ps
module bss_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         i_clock, // oscillator clock
	input  wire logic         i_rst_n, // async reset, active low
	input  wire logic [W-1:0] i_d,     // asynchronous levels
	output logic      [W-1:0] o_q      // synchronised levels
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	always_comb begin
		meta_d = i_d;
		sync_d = meta_q;
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign o_q = sync_q;
endmodule

/* File: verilog/bss_timer.sv */
`timescale 1ns/1ps
module bss_timer (
	input  wire logic i_clock, // oscillator clock
	input  wire logic i_rst_n, // async reset, active low
	bss_tmr_if.tmr    tmr      // start, load, done
);
	import bss_pkg::*;

	logic [TW-1:0] cnt_q;
	logic [TW-1:0] cnt_d;
	logic          run_q;
	logic          run_d;
	logic          done_q;
	logic          done_d;

	// a new start always wins, so a stale count never fires a done;
	// done is registered and acted on a cycle later, so it fires one
	// count early and a state lasts exactly its load (below 2 gives 2)
	always_comb begin
		cnt_d  = cnt_q;
		run_d  = run_q;
		done_d = 1'b0;
		if (tmr.start) begin
			cnt_d = tmr.load;
			run_d = 1'b1;
		end else if (run_q) begin
			if (cnt_q <= TW'(2)) begin
				run_d  = 1'b0;
				done_d = 1'b1;
			end else begin
				cnt_d = cnt_q - TW'(1);
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q  <= '0;
			run_q  <= 1'b0;
			done_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			run_q  <= run_d;
			done_q <= done_d;
		end
	end

	assign tmr.done = done_q;
endmodule

/* File: sim/bss_sequencer_chk.sv */
`timescale 1ns/1ps
module bss_sequencer_chk
	import bss_pkg::*;
#(
	parameter int unsigned P_SS_STEP_CYC = 6
) (
	input wire logic              i_clock,         // clock
	input wire logic              i_rst_n,         // por
	input wire logic              i_bias_ok,       // bias up
	input wire logic              i_enable_ok,     // enable up
	input wire logic              o_lowside_off,   // ls off
	input wire logic              o_trip_src_on,   // src on
	input wire logic [TRIP_W-1:0] o_trip_code,     // trip dac
	input wire logic [REF_W-1:0]  o_ref_code,      // ramp
	input wire logic              o_ea_enable,     // amp on
	input wire logic              o_switch_enable, // fets ok
	input wire logic              o_ss_done,       // done
	input wire logic              o_hiccup         // retry
);
	logic [REF_W-1:0] prev_q;
	logic [15:0]      gap_q;
	logic [15:0]      gap_d;
	logic [15:0]      last_q;
	logic [15:0]      last_d;
	logic             inc;
	// step spacing is measured, so a wrong divider shows as unequal steps
	always_comb begin
		inc    = o_ref_code == prev_q + 7'h01;
		gap_d  = (o_ref_code != prev_q) ? 16'h0001 : gap_q + 16'h0001;
		last_d = inc ? gap_q : last_q;
	end
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prev_q <= '0;
			gap_q  <= '0;
			last_q <= '0;
		end else begin
			prev_q <= o_ref_code;
			gap_q  <= gap_d;
			last_q <= last_d;
		end
	end
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	ref_step_a: assert property ($changed(o_ref_code) |->
		o_ref_code == $past(o_ref_code) + 7'h01 || o_ref_code == 7'h00)
		else $error("ramp code jumped");
	step_even_a: assert property (inc && prev_q >= 7'h02 |->
		gap_q == last_q && gap_q == 16'(P_SS_STEP_CYC))
		else $error("ramp steps uneven");
	ref_range_a: assert property (o_ref_code <= REF_FINAL)
		else $error("ramp code above final");
	done_code_a: assert property (o_ss_done |->
		o_ref_code == REF_FINAL && o_ea_enable)
		else $error("done without final code");
	done_rise_a: assert property ($rose(o_ss_done) |->
		$past(o_ref_code) == REF_LAST)
		else $error("done not after last step");
	bias_clear_a: assert property (!i_bias_ok [*6] |->
		o_trip_code == 8'h00 && o_ref_code == 7'h00 && !o_ss_done)
		else $error("bias low did not clear");
	en_gate_a: assert property (!i_enable_ok [*6] |->
		!o_lowside_off && !o_trip_src_on && !o_ea_enable)
		else $error("ran with enable low");
	settle_hold_a: assert property ($rose(o_lowside_off) |->
		o_trip_src_on ##1 o_lowside_off [*8])
		else $error("settle cut short");
	trip_hold_a: assert property ($changed(o_trip_code) |->
		(o_trip_src_on && o_trip_code == $past(o_trip_code) + 8'h01)
		|| o_trip_code == 8'h00)
		else $error("trip code moved outside sample");
	sw_gate_a: assert property (o_switch_enable |->
		o_ea_enable && !o_hiccup && !o_lowside_off)
		else $error("switches on out of turn");
	hiccup_off_a: assert property (o_hiccup |-> ##[0:1]
		(!o_ea_enable && !o_switch_enable && !o_trip_src_on))
		else $error("output live during retry");
	ea_start_a: assert property ($rose(o_ea_enable) |->
		o_ref_code == 7'h00 && !o_lowside_off)
		else $error("amp enabled early");
	cover property ($rose(o_ss_done));
	cover property ($rose(o_hiccup));
	cover property (o_switch_enable && !o_ss_done);
endmodule

bind bss_sequencer bss_sequencer_chk #(.P_SS_STEP_CYC(P_SS_STEP_CYC)) u_chk (
	.i_clock(i_clock), .i_rst_n(i_rst_n), .i_bias_ok(i_bias_ok),
	.i_enable_ok(i_enable_ok), .o_lowside_off(o_lowside_off),
	.o_trip_src_on(o_trip_src_on), .o_trip_code(o_trip_code),
	.o_ref_code(o_ref_code), .o_ea_enable(o_ea_enable),
	.o_switch_enable(o_switch_enable), .o_ss_done(o_ss_done),
	.o_hiccup(o_hiccup));

/* File: sim/bss_ana_model.sv */
`timescale 1ns/1ps
module bss_ana_model
	import bss_pkg::*;
(
	input  wire logic [TRIP_W-1:0] i_trip_code, // dac code
	input  wire logic [REF_W-1:0]  i_ref_code,  // ramp code
	input  wire logic [TRIP_W-1:0] i_trip_set,  // pin level
	input  wire logic [REF_W-1:0]  i_vout_code, // output level
	output logic                   o_trip_cmp,  // dac >= pin
	output logic                   o_above      // ref > vout
);
	// ideal comparators: no offset, so expected codes are exact
	always_comb begin
		o_trip_cmp = i_trip_code >= i_trip_set;
		o_above    = i_ref_code > i_vout_code;
	end
endmodule

/* File: sim/tb_bss_sequencer.sv */
`timescale 1ns/1ps
module tb_bss_sequencer;
	import bss_pkg::*;
	localparam int STEP = 6;
	logic              i_clock;
	logic              i_rst_n;
	logic              i_bias_ok;
	logic              i_enable_ok;
	logic              i_overcurrent;
	logic              trip_cmp;
	logic              above;
	logic [TRIP_W-1:0] trip_set;
	logic [TRIP_W-1:0] last_t;
	logic [TRIP_W-1:0] o_trip_code;
	logic [REF_W-1:0]  vout;
	logic [REF_W-1:0]  o_ref_code;
	logic              o_lowside_off;
	logic              o_trip_src_on;
	logic              o_ea_enable;
	logic              o_switch_enable;
	logic              o_ss_done;
	logic              o_hiccup;
	int                errors;
	int                cmp_count;
	int                i;
	int                h;

	bss_sequencer #(.P_SETTLE_CYC(20), .P_SAMPLE_CYC(4), .P_INIT_CYC(5),
		.P_SS_STEP_CYC(STEP)) dut (
		.i_clock(i_clock), .i_rst_n(i_rst_n), .i_bias_ok(i_bias_ok),
		.i_enable_ok(i_enable_ok), .i_trip_cmp(trip_cmp),
		.i_ramp_above_vout(above), .i_overcurrent(i_overcurrent),
		.o_lowside_off(o_lowside_off), .o_trip_src_on(o_trip_src_on),
		.o_trip_code(o_trip_code), .o_ref_code(o_ref_code),
		.o_ea_enable(o_ea_enable), .o_switch_enable(o_switch_enable),
		.o_ss_done(o_ss_done), .o_hiccup(o_hiccup));
	bss_ana_model u_ana (.i_trip_code(o_trip_code), .i_ref_code(o_ref_code),
		.i_trip_set(trip_set), .i_vout_code(vout), .o_trip_cmp(trip_cmp),
		.o_above(above));

	always #5 i_clock = ~i_clock;

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("compares=%0d mismatches=%0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic start_up(input logic [7:0] t, input logic [6:0] v);
		int         n;
		logic [6:0] r;
		n = 0;
		r = 7'h7f;
		@(posedge i_clock);
		i_enable_ok <= 1'b0;
		repeat (10) @(negedge i_clock);
		chk(8'({o_ea_enable, o_ss_done}), 8'h00);
		chk(o_trip_code, last_t);
		@(posedge i_clock);
		trip_set    <= t;
		vout        <= v;
		i_enable_ok <= 1'b1;
		while (o_ss_done !== 1'b1 && n < 2500) begin
			@(negedge i_clock);
			n++;
			if (o_switch_enable === 1'b1 && r === 7'h7f)
				r = o_ref_code;
		end
		chk(8'(n < 2500), 8'h01);
		chk(o_trip_code, t);
		chk(8'(o_ref_code), 8'(REF_FINAL));
		if (v < 7'h3f)
			chk(8'(r), 8'(v) + 8'h01);
		else
			chk(8'(r), 8'h40);
		repeat (6) @(negedge i_clock);
		chk(8'(o_switch_enable), 8'h01);
		last_t = t;
		$display("start-up trip=%h vout=%h ended", t, v);
	endtask

	initial begin
		i_clock       = 1'b0;
		i_rst_n       = 1'b0;
		i_bias_ok     = 1'b0;
		i_enable_ok   = 1'b0;
		i_overcurrent = 1'b0;
		trip_set      = 8'h00;
		vout          = 7'h00;
		last_t        = 8'h00;
		errors        = 0;
		cmp_count     = 0;
		void'($urandom(98451));
		repeat (2) @(posedge i_clock);
		i_rst_n <= 1'b1;
		@(negedge i_clock);
		chk(8'({o_lowside_off, o_trip_src_on, o_ea_enable, o_hiccup}), 8'h00);
		chk(o_trip_code | 8'(o_ref_code), 8'h00);
		@(posedge i_clock);
		i_bias_ok <= 1'b1;
		repeat (60) @(negedge i_clock);
		chk(8'({o_lowside_off, o_trip_src_on}), 8'h00);
		$display("enable held low ended");
		start_up(8'h00, 7'h00);
		start_up(8'hff, 7'h50);
		for (i = 0; i < 4; i++)
			start_up(8'($urandom_range(0, 40)), 7'($urandom_range(0, 70)));
		@(posedge i_clock);
		i_overcurrent <= 1'b1;
		repeat (8) @(negedge i_clock);
		chk(8'({o_hiccup, o_switch_enable, o_trip_src_on, o_ss_done}), 8'h08);
		@(posedge i_clock);
		i_overcurrent <= 1'b0;
		i = 0;
		h = 0;
		while (o_ss_done !== 1'b1 && i < 3000) begin
			@(negedge i_clock);
			i++;
			if (o_hiccup === 1'b1)
				h++;
		end
		chk(8'(i < 3000), 8'h01);
		chk(8'(h > 2 * SS_STEPS * STEP - 20 && h < 2 * SS_STEPS * STEP + 20), 8'h01);
		chk(o_trip_code, last_t);
		$display("overcurrent retry ended");
		@(posedge i_clock);
		i_enable_ok <= 1'b0;
		repeat (6) @(posedge i_clock);
		i_enable_ok <= 1'b1;
		i = 0;
		while (o_ea_enable !== 1'b1 && i < 500) begin
			@(negedge i_clock);
			i++;
		end
		chk(8'(i < 500), 8'h01);
		@(posedge i_clock);
		i_overcurrent <= 1'b1;
		repeat (2) @(posedge i_clock);
		i_overcurrent <= 1'b0;
		repeat (4) @(negedge i_clock);
		chk(8'({o_hiccup, o_ea_enable, o_switch_enable}), 8'h04);
		chk(o_trip_code, last_t);
		$display("overcurrent in ramp ended");
		@(posedge i_clock);
		i_bias_ok <= 1'b0;
		repeat (8) @(negedge i_clock);
		chk(o_trip_code | 8'(o_ref_code), 8'h00);
		$display("bias loss ended");
		report_and_stop();
	end

	initial begin
		#400000;
		errors++;
		$display("[FAIL] t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
		report_and_stop();
	end
endmodule
